// ===== rtl/dxp_i2c_target.sv
`timescale 1ns/1ps
module dxp_i2c_target (
  input wire logic link_clock,
  input wire logic link_rst,
  dxp_if.target bus
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_WRITE = 4'b0100,
    ST_READ = 4'b1000
  } dxp_i2c_state_t;

  dxp_i2c_state_t state;
  logic scl_d;
  logic sda_d;
  logic [7:0] shreg;
  logic [3:0] bit_cnt;
  logic first;
  logic start_cond;
  logic stop_cond;
  logic scl_rise;
  logic scl_fall;

  assign start_cond = scl_d & bus.scl_s & sda_d & ~bus.sda_s;
  assign stop_cond = scl_d & bus.scl_s & ~sda_d & bus.sda_s;
  assign scl_rise = bus.scl_s & ~scl_d;
  assign scl_fall = ~bus.scl_s & scl_d;

  always_ff @(posedge link_clock) begin
    if (link_rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= bus.scl_s;
      sda_d <= bus.sda_s;
    end
  end

  always_ff @(posedge link_clock) begin
    bus.wr_valid <= 1'b0;
    bus.rd_take <= 1'b0;
    if (link_rst || stop_cond) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      first <= 1'b0;
      bus.sda_oe_n <= 1'b1;
      bus.wr_data <= 8'h00;
      bus.wr_first <= 1'b0;
    end else if (start_cond) begin
      // Repeated start lands here too
      state <= ST_ADDR;
      bit_cnt <= 4'h0;
      bus.sda_oe_n <= 1'b1;
    end else begin
      case (state)
        ST_ADDR, ST_WRITE: begin
          if (scl_rise && bit_cnt < dxp_pkg::BIT_BYTE) begin
            shreg <= {shreg[6:0], bus.sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == dxp_pkg::BIT_BYTE) begin
            if (state == ST_ADDR && shreg[7:1] != bus.dev_addr) begin
              state <= ST_IDLE;
            end else begin
              bus.sda_oe_n <= 1'b0;
              bit_cnt <= dxp_pkg::BIT_ACK;
            end
            if (state == ST_WRITE) begin
              bus.wr_valid <= 1'b1;
              bus.wr_data <= shreg;
              bus.wr_first <= first;
              first <= 1'b0;
            end
          end else if (scl_fall && bit_cnt == dxp_pkg::BIT_ACK) begin
            if (state == ST_ADDR && shreg[0]) begin
              state <= ST_READ;
              bus.sda_oe_n <= bus.rd_data[7];
              shreg <= {bus.rd_data[6:0], 1'b0};
              bit_cnt <= 4'h1;
              bus.rd_take <= 1'b1;
            end else begin
              bus.sda_oe_n <= 1'b1;
              bit_cnt <= 4'h0;
              if (state == ST_ADDR) begin
                state <= ST_WRITE;
                first <= 1'b1;
              end
            end
          end
        end
        ST_READ: begin
          if (scl_fall && bit_cnt < dxp_pkg::BIT_BYTE) begin
            bus.sda_oe_n <= shreg[7];
            shreg <= {shreg[6:0], 1'b0};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == dxp_pkg::BIT_BYTE) begin
            bus.sda_oe_n <= 1'b1;
            bit_cnt <= dxp_pkg::BIT_ACK;
          end else if (scl_rise && bit_cnt == dxp_pkg::BIT_ACK) begin
            // Controller not-acknowledge ends the read
            if (bus.sda_s) begin
              state <= ST_IDLE;
            end else begin
              bit_cnt <= dxp_pkg::BIT_ACKED;
            end
          end else if (scl_fall && bit_cnt == dxp_pkg::BIT_ACKED) begin
            bus.sda_oe_n <= bus.rd_data[7];
            shreg <= {bus.rd_data[6:0], 1'b0};
            bit_cnt <= 4'h1;
            bus.rd_take <= 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule : dxp_i2c_target

// ===== rtl/dxp_sync.sv
`timescale 1ns/1ps
module dxp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    meta <= async_in;
    sync_out <= meta;
  end

endmodule : dxp_sync

// ===== rtl/dxp_top.sv
// Overview of operation
// - Eight lines each set as input or output, all inputs after reset.
// - Each line has pull up, pull down or none, pull up after reset.
// - In open-drain drive every output line has its pull switched off.
// - One port-wide bit picks push-pull or open-drain for all outputs.
// - Each input line may raise a change interrupt, output lines never do.
// - Input polarity is programmable, normal by default, inverted reads low pins as one.
// - The port answers at I2C address 0x20 to 0x27, low bits from the board jumpers.
`timescale 1ns/1ps
module dxp_top (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic link_clock,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [2:0] board_addr,
  input wire logic io_voltage_jumper,
  input wire logic [7:0] line_in,
  output logic [7:0] line_out,
  output logic [7:0] line_oe_n,
  output logic [7:0] pull_up_en,
  output logic [7:0] pull_down_en,
  output logic host_int_n
);

  dxp_if tgt ();

  // Link domain signals
  logic link_rst;
  logic [2:0] board_s;
  logic jumper_s;
  logic ack_s;
  logic [3:0] ptr;
  logic req_tog;
  dxp_pkg::dxp_cfg_t cfg_live;
  dxp_pkg::dxp_cfg_t cfg_hold;
  dxp_pkg::dxp_stat_t stat_seen;
  logic [7:0] read_byte;

  // Core domain signals
  logic [7:0] pin_s;
  logic req_s;
  logic ack_tog;
  logic req_edge;
  logic clear_ev;
  dxp_pkg::dxp_cfg_t cfg_core;
  dxp_pkg::dxp_stat_t stat_hold;
  logic [7:0] in_level;
  logic [7:0] prev_level;
  logic primed;
  logic [7:0] change;
  logic [7:0] pending;

  function automatic logic [3:0] dxp_next_ptr(input logic [3:0] cur);
    if (cur >= dxp_pkg::REG_LAST) begin
      return 4'h0;
    end
    return cur + 4'h1;
  endfunction : dxp_next_ptr

  // Sampling at link rate works only with a slow bus clock
  dxp_sync #(
    .WIDTH(8)
  ) u_link_sync (
    .clk(link_clock),
    .async_in({sys_rst, scl_in, sda_in, board_addr, io_voltage_jumper, ack_tog}),
    .sync_out({link_rst, tgt.scl_s, tgt.sda_s, board_s, jumper_s, ack_s})
  );

  dxp_sync #(
    .WIDTH(9)
  ) u_core_sync (
    .clk(clock),
    .async_in({line_in, req_tog}),
    .sync_out({pin_s, req_s})
  );

  dxp_i2c_target u_target (
    .link_clock(link_clock),
    .link_rst(link_rst),
    .bus(tgt.target)
  );

  assign tgt.dev_addr = {dxp_pkg::TARGET_ADDR_HIGH, board_s};
  assign tgt.rd_data = read_byte;

  // ---- Link domain: register file reached over I2C ----

  // Data is always zero; the enable alone pulls the wire low
  always_ff @(posedge link_clock) begin
    if (link_rst) begin
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      sda_out <= 1'b0;
      sda_oe_n <= tgt.sda_oe_n;
    end
  end

  always_ff @(posedge link_clock) begin
    if (link_rst) begin
      ptr <= dxp_pkg::REG_INPUT;
    end else if (tgt.wr_valid && tgt.wr_first) begin
      ptr <= tgt.wr_data[3:0];
    end else if (tgt.wr_valid || tgt.rd_take) begin
      ptr <= dxp_next_ptr(ptr);
    end
  end

  always_ff @(posedge link_clock) begin
    if (link_rst) begin
      cfg_live <= dxp_pkg::CFG_RESET;
    end else begin
      if (tgt.wr_valid && !tgt.wr_first) begin
        if (ptr == dxp_pkg::REG_OUTPUT) begin
          cfg_live.out_latch <= tgt.wr_data;
        end else if (ptr == dxp_pkg::REG_POLARITY) begin
          cfg_live.polarity <= tgt.wr_data;
        end else if (ptr == dxp_pkg::REG_DIRECTION) begin
          cfg_live.direction <= tgt.wr_data;
        end else if (ptr == dxp_pkg::REG_PULL_EN) begin
          cfg_live.pull_en <= tgt.wr_data;
        end else if (ptr == dxp_pkg::REG_PULL_SEL) begin
          cfg_live.pull_up <= tgt.wr_data;
        end else if (ptr == dxp_pkg::REG_DRIVE) begin
          cfg_live.drive_od <= tgt.wr_data[dxp_pkg::DRIVE_OD_BIT];
        end else if (ptr == dxp_pkg::REG_INT_EN) begin
          cfg_live.int_en <= tgt.wr_data;
        end
      end
      // Each input read sends a clear token across
      if (tgt.rd_take && ptr == dxp_pkg::REG_INPUT) begin
        cfg_live.clr_tog <= ~cfg_live.clr_tog;
      end
    end
  end

  always_comb begin
    read_byte = 8'h00;
    if (ptr == dxp_pkg::REG_INPUT) begin
      read_byte = stat_seen.level;
    end else if (ptr == dxp_pkg::REG_OUTPUT) begin
      read_byte = cfg_live.out_latch;
    end else if (ptr == dxp_pkg::REG_POLARITY) begin
      read_byte = cfg_live.polarity;
    end else if (ptr == dxp_pkg::REG_DIRECTION) begin
      read_byte = cfg_live.direction;
    end else if (ptr == dxp_pkg::REG_PULL_EN) begin
      read_byte = cfg_live.pull_en;
    end else if (ptr == dxp_pkg::REG_PULL_SEL) begin
      read_byte = cfg_live.pull_up;
    end else if (ptr == dxp_pkg::REG_DRIVE) begin
      read_byte[dxp_pkg::DRIVE_OD_BIT] = cfg_live.drive_od;
    end else if (ptr == dxp_pkg::REG_INT_EN) begin
      read_byte = cfg_live.int_en;
    end else if (ptr == dxp_pkg::REG_PENDING) begin
      read_byte = stat_seen.pending;
    end else if (ptr == dxp_pkg::REG_BOARD) begin
      read_byte[2:0] = board_s;
      read_byte[dxp_pkg::BOARD_JUMPER_BIT] = jumper_s;
    end
  end

  // ---- Crossing: one request/acknowledge loop moves both words ----
  // Each side holds its word until the other side has taken it

  always_ff @(posedge link_clock) begin
    if (link_rst) begin
      req_tog <= 1'b0;
      cfg_hold <= dxp_pkg::CFG_RESET;
      stat_seen <= '0;
    end else if (ack_s == req_tog) begin
      stat_seen <= stat_hold;
      cfg_hold <= cfg_live;
      req_tog <= ~req_tog;
    end
  end

  assign req_edge = req_s ^ ack_tog;
  assign clear_ev = req_edge & (cfg_hold.clr_tog ^ cfg_core.clr_tog);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ack_tog <= 1'b0;
      cfg_core <= dxp_pkg::CFG_RESET;
      stat_hold <= '0;
    end else if (req_edge) begin
      cfg_core <= cfg_hold;
      stat_hold <= '{level: in_level, pending: pending};
      ack_tog <= ~ack_tog;
    end
  end

  // ---- Core domain: line logic ----

  assign in_level = pin_s ^ cfg_core.polarity;
  // Priming hides the first sample after reset
  assign change = (in_level ^ prev_level) & cfg_core.direction & cfg_core.int_en & {8{primed}};

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prev_level <= 8'h00;
      primed <= 1'b0;
    end else begin
      prev_level <= in_level;
      primed <= 1'b1;
    end
  end

  // A new change wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pending <= 8'h00;
    end else begin
      pending <= (pending & ~{8{clear_ev}}) | change;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      host_int_n <= 1'b1;
    end else begin
      host_int_n <= ~|(pending & cfg_core.direction & cfg_core.int_en);
    end
  end

  for (genvar i = 0; i < dxp_pkg::LINES; i++) begin : g_line
    logic is_out;
    logic pull_off;

    assign is_out = ~cfg_core.direction[i];
    assign pull_off = cfg_core.drive_od & is_out;

    always_ff @(posedge clock) begin
      if (sys_rst) begin
        line_out[i] <= 1'b0;
        line_oe_n[i] <= 1'b1;
        pull_up_en[i] <= 1'b1;
        pull_down_en[i] <= 1'b0;
      end else begin
        // Open drain only ever drives low
        line_out[i] <= cfg_core.drive_od ? 1'b0 : cfg_core.out_latch[i];
        if (!is_out) begin
          line_oe_n[i] <= 1'b1;
        end else if (cfg_core.drive_od) begin
          line_oe_n[i] <= cfg_core.out_latch[i];
        end else begin
          line_oe_n[i] <= 1'b0;
        end
        pull_up_en[i] <= cfg_core.pull_en[i] & cfg_core.pull_up[i] & ~pull_off;
        pull_down_en[i] <= cfg_core.pull_en[i] & ~cfg_core.pull_up[i] & ~pull_off;
      end
    end
  end

endmodule : dxp_top

// ===== shared/dxp_if.sv
`timescale 1ns/1ps
interface dxp_if;
  logic scl_s;
  logic sda_s;
  logic [6:0] dev_addr;
  logic wr_valid;
  logic wr_first;
  logic [7:0] wr_data;
  logic rd_take;
  logic [7:0] rd_data;
  logic sda_oe_n;

  modport target (
    input scl_s, sda_s, dev_addr, rd_data,
    output wr_valid, wr_first, wr_data, rd_take, sda_oe_n
  );

  modport regs (
    output scl_s, sda_s, dev_addr, rd_data,
    input wr_valid, wr_first, wr_data, rd_take, sda_oe_n
  );
endinterface : dxp_if

// ===== shared/dxp_pkg.sv
package dxp_pkg;

  localparam int LINES = 8;

  // Register pointer values for the command byte
  localparam logic [3:0] REG_INPUT = 4'h0;
  localparam logic [3:0] REG_OUTPUT = 4'h1;
  localparam logic [3:0] REG_POLARITY = 4'h2;
  localparam logic [3:0] REG_DIRECTION = 4'h3;
  localparam logic [3:0] REG_PULL_EN = 4'h4;
  localparam logic [3:0] REG_PULL_SEL = 4'h5;
  localparam logic [3:0] REG_DRIVE = 4'h6;
  localparam logic [3:0] REG_INT_EN = 4'h7;
  localparam logic [3:0] REG_PENDING = 4'h8;
  localparam logic [3:0] REG_BOARD = 4'h9;
  localparam logic [3:0] REG_LAST = 4'h9;

  // Field positions
  localparam int DRIVE_OD_BIT = 0;
  localparam int BOARD_JUMPER_BIT = 3;

  // Reset values
  localparam logic [7:0] RST_OUTPUT = 8'h00;
  localparam logic [7:0] RST_POLARITY = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'hff;
  localparam logic [7:0] RST_PULL_EN = 8'hff;
  localparam logic [7:0] RST_PULL_SEL = 8'hff;
  localparam logic [7:0] RST_INT_EN = 8'h00;
  localparam logic RST_DRIVE_OD = 1'b0;

  // Upper four bits of the seven-bit target address
  localparam logic [3:0] TARGET_ADDR_HIGH = 4'h4;

  // Bit counter marks within one byte frame
  localparam logic [3:0] BIT_BYTE = 4'h8;
  localparam logic [3:0] BIT_ACK = 4'h9;
  localparam logic [3:0] BIT_ACKED = 4'ha;

  // Timing figures
  localparam int I2C_MAX_KHZ = 400;
  localparam int CLOCK_KHZ = 10000;
  localparam int SCL_MIN_PERIOD_CYC = CLOCK_KHZ / I2C_MAX_KHZ;

  typedef struct packed {
    logic [7:0] out_latch;
    logic [7:0] polarity;
    logic [7:0] direction;
    logic [7:0] pull_en;
    logic [7:0] pull_up;
    logic [7:0] int_en;
    logic drive_od;
    logic clr_tog;
  } dxp_cfg_t;

  typedef struct packed {
    logic [7:0] level;
    logic [7:0] pending;
  } dxp_stat_t;

  localparam dxp_cfg_t CFG_RESET = '{
    out_latch: RST_OUTPUT,
    polarity: RST_POLARITY,
    direction: RST_DIRECTION,
    pull_en: RST_PULL_EN,
    pull_up: RST_PULL_SEL,
    int_en: RST_INT_EN,
    drive_od: RST_DRIVE_OD,
    clr_tog: 1'b0
  };

endpackage : dxp_pkg

// ===== verif/dxp_host_model.sv
`timescale 1ns/1ps
module dxp_host_model (
  output logic scl,
  output logic sda,
  input wire logic sda_wire
);
  // Quarter bit; 250 kHz stays under the bus ceiling
  localparam time Q = 1000ns;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Data bits on sda move a quarter after scl falls, for hold margin
  task automatic start();
    #Q sda = 1'b1;
    #Q scl = 1'b1;
    #Q sda = 1'b0;
    #Q scl = 1'b0;
  endtask : start
  task automatic stop();
    #Q sda = 1'b0;
    #Q scl = 1'b1;
    #Q sda = 1'b1;
    #Q;
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    #Q sda = b;
    #Q scl = 1'b1;
    #Q r = sda_wire;
    #Q scl = 1'b0;
  endtask : bit_io
  task automatic xfer(input logic [7:0] tx, input logic nack, output logic [7:0] rx, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(nack, a);
    ack = !a;
  endtask : xfer
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic k1;
    logic k2;
    logic k3;
    start();
    xfer({a, 1'b0}, 1'b1, r, k1);
    xfer(p, 1'b1, r, k2);
    xfer(d, 1'b1, r, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d);
    logic [7:0] r;
    logic k;
    start();
    xfer({a, 1'b0}, 1'b1, r, k);
    xfer(p, 1'b1, r, k);
    start();
    xfer({a, 1'b1}, 1'b1, r, k);
    xfer(8'hff, 1'b1, d, k);
    stop();
  endtask : rd
endmodule : dxp_host_model

// ===== verif/dxp_top_asserts.sv
`timescale 1ns/1ps
module dxp_top_asserts (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic link_clock,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic [7:0] line_in,
  input wire logic [7:0] line_out,
  input wire logic [7:0] line_oe_n,
  input wire logic [7:0] pull_up_en,
  input wire logic [7:0] pull_down_en,
  input wire logic host_int_n
);
  // Cycles since pins or bus clock last moved, saturating
  logic [3:0] pin_age;
  logic [8:0] scl_age;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pin_age <= 4'hf;
    end else if ($changed(line_in)) begin
      pin_age <= 4'h0;
    end else if (pin_age != 4'hf) begin
      pin_age <= pin_age + 4'h1;
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      scl_age <= 9'h1ff;
    end else if ($changed(scl_in)) begin
      scl_age <= 9'h000;
    end else if (scl_age != 9'h1ff) begin
      scl_age <= scl_age + 9'h001;
    end
  end
  a_rst_lines: assert property (@(posedge clock) sys_rst |=>
    line_oe_n == 8'hff && line_out == 8'h00 && pull_up_en == 8'hff && pull_down_en == 8'h00)
    else $error("line outputs not at reset values");
  a_rst_int: assert property (@(posedge clock) $fell(sys_rst) |-> host_int_n [*3])
    else $error("interrupt active right after reset");
  // A short reset spans only a few link edges, so check at its release
  a_rst_sda: assert property (@(posedge link_clock) $fell(sys_rst) |-> sda_oe_n [*2])
    else $error("sda driven during reset");
  a_sda_zero: assert property (@(posedge link_clock) disable iff (sys_rst) sda_out == 1'b0)
    else $error("sda driven high");
  a_sda_steady: assert property (@(posedge link_clock) disable iff (sys_rst)
    scl_in [*4] |-> $stable(sda_oe_n))
    else $error("sda moved while scl high");
  a_pull_excl: assert property (@(posedge clock) disable iff (sys_rst)
    (pull_up_en & pull_down_en) == 8'h00)
    else $error("pull up and down together");
  a_int_cause: assert property (@(posedge clock) disable iff (sys_rst)
    $fell(host_int_n) |-> pin_age <= 4'h8)
    else $error("interrupt without pin change");
  a_int_hold: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(host_int_n) |-> scl_age < 9'd100)
    else $error("interrupt cleared without host access");
  a_cfg_quiet: assert property (@(posedge clock) disable iff (sys_rst)
    $changed({line_oe_n, line_out, pull_up_en, pull_down_en}) |-> scl_age < 9'd60)
    else $error("line setup changed without host write");
  c_int: cover property (@(posedge clock) $fell(host_int_n));
  c_ack: cover property (@(posedge link_clock) $fell(sda_oe_n));
  c_cfg: cover property (@(posedge clock) $changed(line_oe_n));
endmodule : dxp_top_asserts

bind dxp_top dxp_top_asserts chk_u (
  .clock(clock),
  .sys_rst(sys_rst),
  .link_clock(link_clock),
  .scl_in(scl_in),
  .sda_out(sda_out),
  .sda_oe_n(sda_oe_n),
  .line_in(line_in),
  .line_out(line_out),
  .line_oe_n(line_oe_n),
  .pull_up_en(pull_up_en),
  .pull_down_en(pull_down_en),
  .host_int_n(host_int_n)
);

// ===== verif/test_dxp_top.sv
`timescale 1ns/1ps
module test_dxp_top;
  logic clock;
  logic link_clock;
  logic sys_rst;
  logic scl;
  logic host_sda;
  logic sda_in;
  logic sda_out;
  logic sda_oe_n;
  logic [2:0] board_addr;
  logic io_voltage_jumper;
  logic [7:0] line_in;
  logic [7:0] line_out;
  logic [7:0] line_oe_n;
  logic [7:0] pull_up_en;
  logic [7:0] pull_down_en;
  logic host_int_n;
  int fail_count = 0;
  int compares = 0;
  // Pull-up on sda; either party may pull it low
  assign sda_in = host_sda & (sda_oe_n | sda_out);
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    link_clock = 1'b0;
    #37;
    forever #80 link_clock = ~link_clock;
  end
  dxp_top dut_u (
    .clock(clock),
    .sys_rst(sys_rst),
    .link_clock(link_clock),
    .scl_in(scl),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .board_addr(board_addr),
    .io_voltage_jumper(io_voltage_jumper),
    .line_in(line_in),
    .line_out(line_out),
    .line_oe_n(line_oe_n),
    .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en),
    .host_int_n(host_int_n)
  );
  dxp_host_model host_u (
    .scl(scl),
    .sda(host_sda),
    .sda_wire(sda_in)
  );
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    if (fail_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  // Settling wait covers the crossing latency of a write
  task automatic wr(input logic [3:0] p, input logic [7:0] d);
    logic ok;
    @(posedge clock);
    #1;
    host_u.wr(7'h25, {4'h0, p}, d, ok);
    chk({7'h0, ok}, 8'h01);
    repeat (30) @(posedge clock);
    // Look after the edge, never in its own time step
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] p, output logic [7:0] d);
    @(posedge clock);
    #1;
    host_u.rd(7'h25, {4'h0, p}, d);
  endtask : rd
  task automatic pins(input logic [7:0] v);
    @(posedge clock);
    #1 line_in = v;
  endtask : pins
  initial begin
    repeat (80000) @(posedge clock);
    fail_count++;
    final_report();
  end
  initial begin
    logic [7:0] d;
    logic ok;
    sys_rst = 1'b1;
    board_addr = 3'h5;
    io_voltage_jumper = 1'b1;
    line_in = 8'h5a;
    repeat (5) @(posedge clock);
    #1 sys_rst = 1'b0;
    chk(line_oe_n, 8'hff);
    chk(pull_up_en, 8'hff);
    chk(pull_down_en, 8'h00);
    chk({7'h0, host_int_n}, 8'h01);
    repeat (40) @(posedge clock);
    host_u.wr(7'h22, 8'h01, 8'hff, ok);
    chk({7'h0, ok}, 8'h00);
    rd(dxp_pkg::REG_BOARD, d);
    chk(d, 8'h0d);
    wr(dxp_pkg::REG_OUTPUT, 8'ha5);
    chk(line_oe_n, 8'hff);
    wr(dxp_pkg::REG_DIRECTION, 8'hf0);
    chk(line_oe_n, 8'hf0);
    chk(line_out & 8'h0f, 8'h05);
    wr(dxp_pkg::REG_PULL_EN, 8'h7f);
    wr(dxp_pkg::REG_PULL_SEL, 8'h5a);
    chk(pull_up_en & 8'hf0, 8'h50);
    chk(pull_down_en & 8'hf0, 8'h20);
    wr(dxp_pkg::REG_DRIVE, 8'h01);
    chk(line_oe_n, 8'hf5);
    chk(line_out & 8'h0f, 8'h00);
    chk({pull_up_en[3:0], pull_down_en[3:0]}, 8'h00);
    chk(pull_up_en & 8'hf0, 8'h50);
    wr(dxp_pkg::REG_DRIVE, 8'h00);
    chk(line_oe_n, 8'hf0);
    chk(line_out & 8'h0f, 8'h05);
    wr(dxp_pkg::REG_POLARITY, 8'hf0);
    rd(dxp_pkg::REG_INPUT, d);
    chk(d & 8'hf0, 8'ha0);
    wr(dxp_pkg::REG_POLARITY, 8'h00);
    rd(dxp_pkg::REG_INPUT, d);
    chk(d & 8'hf0, 8'h50);
    // Enabled on input bit 4 and output bit 2
    wr(dxp_pkg::REG_INT_EN, 8'h14);
    pins(8'h7e);
    repeat (20) @(posedge clock);
    #1;
    chk({7'h0, host_int_n}, 8'h01);
    pins(8'h6e);
    repeat (8) @(posedge clock);
    #1;
    chk({7'h0, host_int_n}, 8'h00);
    rd(dxp_pkg::REG_PENDING, d);
    chk(d, 8'h10);
    chk({7'h0, host_int_n}, 8'h00);
    rd(dxp_pkg::REG_INPUT, d);
    repeat (20) @(posedge clock);
    #1;
    chk({7'h0, host_int_n}, 8'h01);
    final_report();
  end
endmodule : test_dxp_top
